// File: rtl/adc_ctl_pkg.sv
// What this block does
// R1 - Mux routes one of 24 channels.
// R2 - Completion stores result, then flag or interrupt.
// R3 - Selected pin forced input; others stay port-controlled.
// R4 - Port writes cannot drive the selected pin.
// R5 - Port read of selected pin returns zero.
// R6 - Full scale 3FF, zero 000, linear.
// R7 - Status register write starts a conversion.
// R8 - Conversion takes 16 to 17 converter clocks.
// R9 - Software sets converter clock near 1 MHz.
// R10 - Continuous mode overwrites results until cleared.
// R11 - Completion flag stays until result read.
// R12 - Single mode: one conversion per write.
// R13 - Software discards result if restarted mid-conversion.
// R14 - Four result formats chosen by format bits.
// R15 - Left mode splits 8/2; high read locks storing.
// R16 - Right mode splits 2/8.
// R17 - Signed left mode inverts result msb.
// R18 - Truncation keeps top eight bits, no interlock.
// R19 - Interrupt enabled: interrupt, flag unused.
// R20 - Wait mode keeps running; interrupt can wake.
// R21 - Stop aborts; resume with one stabilizing conversion.
// R22 - All-ones channel powers off; stabilize after.
// R23 - Result read or status write clears interrupt.
// R24 - High read freezes low until low read.
package adc_ctl_pkg;
  // Register indices on the two-bit address port.
  localparam logic [1:0] ADDR_STATUS = 2'h0;
  localparam logic [1:0] ADDR_RES_HI = 2'h1;
  localparam logic [1:0] ADDR_RES_LO = 2'h2;
  localparam logic [1:0] ADDR_CLOCK = 2'h3;
  // Field positions.
  localparam int SC_COMPLETION_FLAG = 7;
  localparam int SC_IRQ_ENABLE = 6;
  localparam int SC_CONTINUOUS_ENABLE = 5;
  localparam int CK_PRESC_LSB = 5;
  localparam int CK_CLKSEL = 4;
  localparam int CK_FMT_LSB = 2;
  // Result formats.
  localparam logic [1:0] FMT_LEFT = 2'h0;
  localparam logic [1:0] FMT_RIGHT = 2'h1;
  localparam logic [1:0] FMT_SIGNED = 2'h2;
  localparam logic [1:0] FMT_TRUNC = 2'h3;
  // Values after reset and fixed codes.
  localparam logic [4:0] CH_OFF = 5'h1F;
  localparam logic [2:0] RST_PRESC = 3'h0;
  localparam logic RST_CLKSEL = 1'b0;
  localparam logic [1:0] RST_FMT = FMT_LEFT;
  // Index of the last converter clock of a conversion (17 ticks, 16 to 17 periods).
  localparam logic [4:0] CONV_LAST = 5'h10;
  localparam logic [3:0] SAR_TOP = 4'h9;
  localparam logic [3:0] SAR_STEPS = 4'hA;
  // Conversion states.
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STAB = 3'b010,
    ST_CONV = 3'b100
  } conv_state_e;
endpackage : adc_ctl_pkg

// File: rtl/adc_conversion_control.sv
`timescale 1ns/10ps
`default_nettype none
module adc_conversion_control #(
  parameter int NUM_CH = 24
) (
  // Clock and reset.
  input wire logic i_clk,
  input wire logic i_nrst,
  // Register port.
  input wire logic [1:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  // Converter core.
  input wire logic i_osc_tick,
  input wire logic i_cmp,
  output logic [9:0] o_dac,
  output logic [4:0] o_mux_sel,
  output logic o_powered,
  // Low-power and interrupt.
  input wire logic i_stop,
  output logic o_irq,
  // Shared port pins.
  input wire logic [NUM_CH-1:0] i_port_dir,
  input wire logic [NUM_CH-1:0] i_port_out,
  input wire logic [NUM_CH-1:0] i_pin_in,
  output logic [NUM_CH-1:0] o_pin_oe,
  output logic [NUM_CH-1:0] o_pin_out,
  output logic [NUM_CH-1:0] o_port_rd
);

  typedef struct packed {
    adc_ctl_pkg::conv_state_e state;
    logic [3:0] div;
    logic [4:0] cyc;
    logic [3:0] bidx;
    logic [9:0] dac;
    logic [7:0] res_hi;
    logic [7:0] res_lo;
    logic completion_flag;
    logic irqp;
    logic irq_enable;
    logic continuous_enable;
    logic [4:0] ch;
    logic [2:0] presc;
    logic clksel;
    logic [1:0] fmt;
    logic lock;
    logic stab;
    logic resume;
    logic stop;
    logic [7:0] rdata;
    logic [NUM_CH-1:0] pin_oe;
    logic [NUM_CH-1:0] pin_out;
    logic [NUM_CH-1:0] port_rd;
  } ctl_s;

  ctl_s s_q;
  ctl_s s_d;
  logic tick;
  logic done;
  logic [3:0] lim;
  logic interlock;
  logic start;
  logic [NUM_CH-1:0] sel_c;

  // Places the raw 10-bit code into the high and low result registers.
  function automatic logic [15:0] pack_res(input logic [1:0] fmt, input logic [9:0] r);
    logic [15:0] v;
    v = '0;
    case (fmt)
      adc_ctl_pkg::FMT_LEFT: v = {r[9:2], r[1:0], 6'h00}; // R15
      adc_ctl_pkg::FMT_RIGHT: v = {6'h00, r[9:8], r[7:0]}; // R16
      adc_ctl_pkg::FMT_SIGNED: v = {~r[9], r[8:2], r[1:0], 6'h00}; // R17
      adc_ctl_pkg::FMT_TRUNC: v = {8'h00, r[9:2]}; // R18
      default: v = '0;
    endcase
    return v; // R14
  endfunction : pack_res

  // One decode per shared pin; the powered-off code selects no pin.
  generate
    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_sel
      assign sel_c[g] = (s_q.ch == 5'(g)); // R1
    end
  endgenerate

  // Next state of the whole block.
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 8'h00;
    tick = 1'b0;
    start = 1'b0;
    interlock = (s_q.fmt != adc_ctl_pkg::FMT_TRUNC);
    lim = s_q.presc[2] ? 4'hF : 4'((4'h1 << s_q.presc[1:0]) - 4'h1);

    // Prescaler runs only while converting, so each start sees a fresh phase.
    if (s_q.state != adc_ctl_pkg::ST_IDLE && (s_q.clksel || i_osc_tick))
    begin
      if (s_q.div == lim)
      begin
        s_d.div = 4'h0;
        tick = 1'b1;
      end
      else
      begin
        s_d.div = s_q.div + 4'h1;
      end
    end
    done = tick && (s_q.cyc == adc_ctl_pkg::CONV_LAST); // R8

    // Successive approximation: trial bit set, kept if the comparator says so.
    if (tick)
    begin
      s_d.cyc = s_q.cyc + 5'h01;
      if (s_q.cyc == 5'h00)
      begin
        s_d.dac = 10'h200;
        s_d.bidx = adc_ctl_pkg::SAR_TOP;
      end
      else if (s_q.cyc <= 5'(adc_ctl_pkg::SAR_STEPS))
      begin
        if (!i_cmp)
          s_d.dac[s_q.bidx] = 1'b0; // R6
        if (s_q.bidx != 4'h0)
        begin
          s_d.dac[s_q.bidx - 4'h1] = 1'b1;
          s_d.bidx = s_q.bidx - 4'h1;
        end
      end
    end

    // Register reads; flag clears come first so a same-cycle set wins.
    if (i_rd)
    begin
      case (i_addr)
        adc_ctl_pkg::ADDR_STATUS:
          s_d.rdata = {s_q.completion_flag & ~s_q.irq_enable, s_q.irq_enable, s_q.continuous_enable, s_q.ch};
        adc_ctl_pkg::ADDR_RES_HI:
        begin
          s_d.rdata = s_q.res_hi;
          s_d.lock = interlock; // R24
          s_d.completion_flag = 1'b0; // R11
          s_d.irqp = 1'b0; // R23
        end
        adc_ctl_pkg::ADDR_RES_LO:
        begin
          s_d.rdata = s_q.res_lo;
          s_d.lock = 1'b0; // R24
          s_d.completion_flag = 1'b0;
          s_d.irqp = 1'b0; // R23
        end
        adc_ctl_pkg::ADDR_CLOCK:
          s_d.rdata = {s_q.presc, s_q.clksel, s_q.fmt, 2'b00};
        default: s_d.rdata = 8'h00;
      endcase
    end

    // Register writes; the completion bit position is not writable.
    if (i_wr)
    begin
      case (i_addr)
        adc_ctl_pkg::ADDR_STATUS:
        begin
          s_d.irq_enable = i_wdata[adc_ctl_pkg::SC_IRQ_ENABLE];
          s_d.continuous_enable = i_wdata[adc_ctl_pkg::SC_CONTINUOUS_ENABLE];
          s_d.ch = i_wdata[4:0];
          s_d.irqp = 1'b0; // R23
          start = 1'b1; // R7
        end
        adc_ctl_pkg::ADDR_CLOCK:
        begin
          s_d.presc = i_wdata[adc_ctl_pkg::CK_PRESC_LSB +: 3];
          s_d.clksel = i_wdata[adc_ctl_pkg::CK_CLKSEL];
          s_d.fmt = i_wdata[adc_ctl_pkg::CK_FMT_LSB +: 2]; // R14
        end
        default: s_d.fmt = s_d.fmt;
      endcase
    end

    // End of a conversion or of the stabilizing dummy conversion.
    if (done)
    begin
      s_d.cyc = 5'h00;
      if (s_q.state == adc_ctl_pkg::ST_STAB)
      begin
        s_d.state = adc_ctl_pkg::ST_CONV; // R21
        s_d.stab = 1'b0; // R22
      end
      else
      begin
        // A pending high/low read pair blocks storing in interlocked formats.
        if (!(s_q.lock && interlock))
          {s_d.res_hi, s_d.res_lo} = pack_res(s_q.fmt, s_q.dac); // R2 R10 R15
        if (s_q.irq_enable)
          s_d.irqp = 1'b1; // R19
        else
          s_d.completion_flag = 1'b1; // R11
        if (!s_q.continuous_enable)
          s_d.state = adc_ctl_pkg::ST_IDLE; // R12
      end
    end

    // A status write restarts; results of an interrupted conversion are lost.
    if (start)
    begin
      s_d.cyc = 5'h00;
      s_d.div = 4'h0;
      if (i_wdata[4:0] == adc_ctl_pkg::CH_OFF)
      begin
        s_d.state = adc_ctl_pkg::ST_IDLE; // R22
        s_d.stab = 1'b1;
      end
      else if (s_q.stab)
        s_d.state = adc_ctl_pkg::ST_STAB; // R22
      else
        s_d.state = adc_ctl_pkg::ST_CONV; // R7
    end

    // Stop halts the conversion; on exit the interrupted work resumes after a dummy.
    s_d.stop = i_stop;
    if (i_stop)
    begin
      if (s_d.state != adc_ctl_pkg::ST_IDLE || s_q.resume)
        s_d.resume = s_d.ch != adc_ctl_pkg::CH_OFF;
      s_d.state = adc_ctl_pkg::ST_IDLE; // R21
      s_d.stab = 1'b1;
      s_d.cyc = 5'h00;
    end
    else if (s_q.stop && s_q.resume)
    begin
      s_d.resume = 1'b0;
      s_d.cyc = 5'h00;
      s_d.div = 4'h0;
      s_d.state = adc_ctl_pkg::ST_STAB; // R21
    end

    // Pin takeover, registered so every pin output comes from a flip-flop.
    s_d.pin_oe = i_port_dir & ~sel_c; // R3 R4
    s_d.pin_out = i_port_out; // R4
    s_d.port_rd = i_pin_in & ~sel_c; // R5
  end

  // Single state register.
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s_q <= '0;
      s_q.state <= adc_ctl_pkg::ST_IDLE;
      s_q.ch <= adc_ctl_pkg::CH_OFF;
      s_q.presc <= adc_ctl_pkg::RST_PRESC;
      s_q.clksel <= adc_ctl_pkg::RST_CLKSEL;
      s_q.fmt <= adc_ctl_pkg::RST_FMT;
      s_q.stab <= 1'b1;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // Outputs; the interrupt keeps working in wait mode so it can wake the core.
  assign o_rdata = s_q.rdata;
  assign o_dac = s_q.dac; // R6
  assign o_mux_sel = s_q.ch; // R1
  assign o_powered = (s_q.ch != adc_ctl_pkg::CH_OFF) && !s_q.stop; // R22
  assign o_irq = s_q.irqp; // R19 R20
  assign o_pin_oe = s_q.pin_oe;
  assign o_pin_out = s_q.pin_out;
  assign o_port_rd = s_q.port_rd;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // Checks on the sequencing, flags, formatting and pin takeover.
  AST_PIN_INPUT: assert property ( // R3
    s_q.ch < 5'(NUM_CH) && $stable(s_q.ch) |-> !o_pin_oe[s_q.ch])
    else $error("selected pin is driven");
  AST_PIN_READ_ZERO: assert property ( // R5
    s_q.ch < 5'(NUM_CH) && $stable(s_q.ch) |-> !o_port_rd[s_q.ch])
    else $error("selected pin reads nonzero");
  AST_START: assert property ( // R7
    i_wr && i_addr == adc_ctl_pkg::ADDR_STATUS && i_wdata[4:0] != adc_ctl_pkg::CH_OFF
    && !i_stop |=> s_q.state != adc_ctl_pkg::ST_IDLE)
    else $error("status write did not start");
  AST_LENGTH: assert property ( // R8
    done |-> s_q.cyc == 5'h10 && s_q.state != adc_ctl_pkg::ST_IDLE)
    else $error("conversion ended at wrong count");
  AST_FLAG_SET: assert property ( // R11
    done && s_q.state == adc_ctl_pkg::ST_CONV && !s_q.irq_enable && !i_stop
    |=> s_q.completion_flag ##0 o_irq == $past(o_irq) || $past(o_irq))
    else $error("completion flag not set");
  AST_IRQ_SET: assert property ( // R19
    done && s_q.state == adc_ctl_pkg::ST_CONV && s_q.irq_enable |=> o_irq ##1 1'b1)
    else $error("interrupt not raised");
  AST_IRQ_CLR: assert property ( // R23
    i_wr && i_addr == adc_ctl_pkg::ADDR_STATUS && !done |=> !o_irq)
    else $error("interrupt not cleared");
  AST_FREEZE: assert property ( // R24
    s_q.lock && interlock && !(i_wr && i_addr == adc_ctl_pkg::ADDR_CLOCK)
    |=> $stable(s_q.res_lo))
    else $error("low result changed while locked");
  AST_TRUNC_HIGH: assert property ( // R18
    done && s_q.state == adc_ctl_pkg::ST_CONV && s_q.fmt == adc_ctl_pkg::FMT_TRUNC
    |=> s_q.res_hi == 8'h00)
    else $error("high result not zero in truncation");
  AST_STOP: assert property ( // R21
    i_stop |=> s_q.state == adc_ctl_pkg::ST_IDLE [*1] ##0 !done)
    else $error("stop did not halt");
  AST_POWER_OFF: assert property ( // R22
    s_q.ch == adc_ctl_pkg::CH_OFF && $past(s_q.ch) == adc_ctl_pkg::CH_OFF
    && !$past(s_q.stop) |-> s_q.state == adc_ctl_pkg::ST_IDLE)
    else $error("converter running while off");

  // Read data stand for one cycle only, so a stale byte is never taken twice.
  AST_RDATA_IDLE: assert property ( // R7
    !i_rd |=> o_rdata == 8'h00)
    else $error("read data not cleared");
  AST_COMPLETION_FLAG_HIDDEN: assert property ( // R19
    i_rd && i_addr == adc_ctl_pkg::ADDR_STATUS && s_q.irq_enable |=> !o_rdata[7])
    else $error("completion flag visible in interrupt mode");
  AST_READ_CLEARS: assert property ( // R11
    i_rd && (i_addr == adc_ctl_pkg::ADDR_RES_HI || i_addr == adc_ctl_pkg::ADDR_RES_LO)
    && !done |=> !s_q.completion_flag && !o_irq)
    else $error("result read did not clear flags");

  // High/low interlock bookkeeping.
  AST_LOCK_SET: assert property ( // R24
    i_rd && i_addr == adc_ctl_pkg::ADDR_RES_HI && interlock |=> s_q.lock)
    else $error("high read did not lock");
  AST_LOCK_CLR: assert property ( // R24
    i_rd && i_addr == adc_ctl_pkg::ADDR_RES_LO |=> !s_q.lock)
    else $error("low read did not unlock");

  // Sequencing after a completed conversion.
  AST_CONT_RESTART: assert property ( // R10
    done && s_q.state == adc_ctl_pkg::ST_CONV && s_q.continuous_enable && !i_stop && !i_wr
    |=> s_q.state == adc_ctl_pkg::ST_CONV)
    else $error("continuous mode stopped");
  AST_SINGLE_END: assert property ( // R12
    done && s_q.state == adc_ctl_pkg::ST_CONV && !s_q.continuous_enable && !i_wr
    |=> s_q.state == adc_ctl_pkg::ST_IDLE)
    else $error("single mode kept converting");
  AST_DUMMY_NO_STORE: assert property ( // R22
    done && s_q.state == adc_ctl_pkg::ST_STAB
    |=> $stable(s_q.res_hi) && $stable(s_q.res_lo))
    else $error("stabilizing conversion stored a result");
  AST_DAC_FIRST: assert property ( // R6
    tick && s_q.cyc == 5'h00 |=> o_dac == 10'h200)
    else $error("first trial code wrong");

  // Stop and pin hand-back; a non-pin channel leaves every port read untouched.
  AST_STOP_POWER: assert property ( // R21
    i_stop |=> !o_powered)
    else $error("converter powered in stop");
  AST_PORT_PASS: assert property ( // R3
    s_q.ch >= 5'(NUM_CH) |=> o_port_rd == $past(i_pin_in))
    else $error("unselected pin read altered");

  COV_CONTINUOUS: cover property (
    done && s_q.continuous_enable && s_q.state == adc_ctl_pkg::ST_CONV ##[17:400] done);
  COV_LOCKED: cover property (done && s_q.lock && interlock);
  COV_STOP_ABORT: cover property (s_q.state == adc_ctl_pkg::ST_CONV ##1 i_stop);
  COV_STAB: cover property (s_q.state == adc_ctl_pkg::ST_STAB ##1 s_q.state == adc_ctl_pkg::ST_CONV);

endmodule : adc_conversion_control
`default_nettype wire

// File: verification/adc_analog_model.sv
`timescale 1ns/10ps
`default_nettype none
module adc_analog_model (
  // Converter side.
  input wire logic [9:0] i_level,
  input wire logic [9:0] i_dac,
  input wire logic [4:0] i_sel,
  output logic o_cmp,
  // Pin side.
  input wire logic [23:0] i_oe,
  input wire logic [23:0] i_out,
  output logic [23:0] o_pin
);
  // Off-range channels give a changing answer, so nothing converts by luck.
  assign o_cmp = (i_sel < 5'h18) ? (i_level >= i_dac) : i_dac[0];
  // Undriven pins rest at the pull-up level.
  assign o_pin = (i_oe & i_out) | ~i_oe;
endmodule : adc_analog_model
`default_nettype wire

// File: verification/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("mismatch at %0t: got %h expected %h", $time, a, b); end end
module tb_top;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic [1:0] i_addr = 2'h0;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_osc_tick = 1'b0;
  logic i_stop = 1'b0;
  logic [23:0] i_port_dir = 24'hFF_FFFF;
  logic [23:0] i_port_out = 24'hFF_FFFF;
  logic [9:0] level = 10'h000;
  logic [7:0] o_rdata, d;
  logic [9:0] o_dac;
  logic [4:0] o_mux_sel;
  logic o_powered, o_irq, i_cmp;
  logic [23:0] i_pin_in, o_pin_oe, o_pin_out, o_port_rd;
  int fail_count = 0;
  int n_checks = 0;
  int n;

  adc_conversion_control i_dut (.i_clk, .i_nrst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata,
    .i_osc_tick, .i_cmp, .o_dac, .o_mux_sel, .o_powered, .i_stop, .o_irq, .i_port_dir,
    .i_port_out, .i_pin_in, .o_pin_oe, .o_pin_out, .o_port_rd);
  adc_analog_model i_model (.i_level(level), .i_dac(o_dac), .i_sel(o_mux_sel), .o_cmp(i_cmp),
    .i_oe(o_pin_oe), .i_out(o_pin_out), .o_pin(i_pin_in));

  // Bus clock and an oscillator enable at half its rate.
  always #12.5 i_clk = ~i_clk;
  always @(posedge i_clk) i_osc_tick <= ~i_osc_tick;

  task automatic test_done();
    if (fail_count == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : test_done

  // One-cycle write strobe.
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe edge.
  task automatic rchk(input logic [1:0] a, input logic [7:0] e, input bit chk = 1);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    if (chk)
      `CHK(d, e)
  endtask : rchk

  // Polling is bounded so a lost completion cannot hang the run.
  task automatic wait_done();
    d = 8'h00;
    for (int k = 0; k < 300 && d[7] !== 1'b1; k++)
      rchk(adc_ctl_pkg::ADDR_STATUS, 8'h00, 0);
    `CHK(d[7], 1'b1)
  endtask : wait_done

  task automatic wait_irq();
    n = 0;
    while (o_irq !== 1'b1 && n < 100)
    begin
      @(posedge i_clk);
      #1;
      n++;
    end
  endtask : wait_irq

  task automatic setlv(input logic [9:0] v);
    @(posedge i_clk);
    level <= v;
    repeat (50) @(posedge i_clk);
  endtask : setlv

  // Expected high and low bytes for each result format.
  function automatic logic [15:0] fmt(input logic [1:0] f, input logic [9:0] r);
    case (f)
      2'h0: fmt = {r, 6'h00};
      2'h1: fmt = {6'h00, r};
      2'h2: fmt = {~r[9], r[8:0], 6'h00};
      default: fmt = {8'h00, r[9:2]};
    endcase
  endfunction : fmt

  // Select 0 runs the oscillator path at /2, select 1 the bus clock at /1.
  task automatic conv(input logic [9:0] v, input logic [1:0] f, input logic s);
    logic [15:0] e;
    e = fmt(f, v);
    setlv(v);
    wr(adc_ctl_pkg::ADDR_CLOCK, {2'h0, ~s, s, f, 2'h0});
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    wait_done();
    rchk(adc_ctl_pkg::ADDR_RES_HI, e[15:8]);
    rchk(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    rchk(adc_ctl_pkg::ADDR_RES_LO, e[7:0]);
  endtask : conv

  // Watchdog well beyond the fewer than two thousand cycles the sequence needs.
  initial
  begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    test_done();
  end

  initial
  begin
    repeat (12) @(posedge i_clk);
    i_nrst <= 1'b1;
    rchk(adc_ctl_pkg::ADDR_STATUS, 8'h1F);
    rchk(adc_ctl_pkg::ADDR_CLOCK, 8'h00);
    for (int f = 0; f < 4; f++)
      conv(10'h2D5, f[1:0], f != 0);
    conv(10'h3FF, 2'h1, 1'b1);
    conv(10'h000, 2'h1, 1'b1);
    `CHK(o_mux_sel, 5'h03)
    `CHK(o_pin_oe, 24'hFF_FFF7)
    `CHK(o_port_rd, 24'hFF_FFF7)
    `CHK(o_pin_out, 24'hFF_FFFF)
    // Interrupt mode in truncation format: timing, flag masking and both clears.
    wr(adc_ctl_pkg::ADDR_CLOCK, 8'h1C);
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h43);
    wait_irq();
    `CHK(n, 17)
    rchk(adc_ctl_pkg::ADDR_STATUS, 8'h43);
    rchk(adc_ctl_pkg::ADDR_RES_HI, 8'h00);
    `CHK(o_irq, 1'b0)
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h43);
    wait_irq();
    `CHK(o_irq, 1'b1)
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    #1;
    `CHK(o_irq, 1'b0)
    wait_done();
    // Continuous mode in left format: overwrite and the high/low interlock.
    wr(adc_ctl_pkg::ADDR_CLOCK, 8'h10);
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h23);
    setlv(10'h155);
    setlv(10'h2AB);
    rchk(adc_ctl_pkg::ADDR_RES_HI, 8'hAA);
    setlv(10'h001);
    rchk(adc_ctl_pkg::ADDR_RES_LO, 8'hC0);
    setlv(10'h001);
    // Restart first, so no stale completion from the free-running mode fools the poll.
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    rchk(adc_ctl_pkg::ADDR_RES_HI, 8'h00);
    rchk(adc_ctl_pkg::ADDR_RES_LO, 8'h40);
    wait_done();
    rchk(adc_ctl_pkg::ADDR_RES_HI, 8'h00);
    rchk(adc_ctl_pkg::ADDR_RES_LO, 8'h40);
    repeat (60) @(posedge i_clk);
    rchk(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    // Stop in mid-conversion aborts; the conversion resumes afterwards.
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    repeat (5) @(posedge i_clk);
    i_stop <= 1'b1;
    repeat (3) @(posedge i_clk);
    #1;
    `CHK(o_powered, 1'b0)
    repeat (60) @(posedge i_clk);
    rchk(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    @(posedge i_clk);
    i_stop <= 1'b0;
    wait_done();
    rchk(adc_ctl_pkg::ADDR_RES_HI, 8'h00);
    rchk(adc_ctl_pkg::ADDR_RES_LO, 8'h40);
    // The all-ones channel powers down and refuses to convert.
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h1F);
    repeat (2) @(posedge i_clk);
    #1;
    `CHK(o_powered, 1'b0)
    repeat (60) @(posedge i_clk);
    rchk(adc_ctl_pkg::ADDR_STATUS, 8'h1F);
    wr(adc_ctl_pkg::ADDR_STATUS, 8'h03);
    wait_done();
    test_done();
  end
endmodule : tb_top
`undef CHK
`default_nettype wire
